// file: dv/adc_conversion_control_test.sv
// Self-checking bench for the conversion control block.
// Assumes AHB-Lite with one slave whose hreadyout is the bus hready.
`timescale 1ns/1ps
module adc_conversion_control_test;
	//----------------------------------------------------------------
	// Signals
	//----------------------------------------------------------------
	localparam logic [4:0] TEMP_CH = 5'h1E; // Temperature channel number
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, rdat;
	logic [1:0] htrans, ref_sel;
	logic [2:0] hsize;
	logic ev_req, ev_start, rr_ev, over, ref_sup, cap_sel, temp_en, conv;
	logic stby, pdown, clk_req, rdy_irq, win_irq;
	logic [4:0] in_sel;
	logic [9:0] core_d;
	logic [10:0] level;
	int err_count, n_compared, cyc, ncv, d, lo, hi, ch, n;
	adc_conversion_control #(.TEMP_CHANNEL(TEMP_CH)) dut_u (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .event_start(ev_start), .result_ready_event(rr_ev),
		.core_sample_data(core_d), .core_over_range(over),
		.input_select(in_sel), .reference_select(ref_sel),
		.ref_use_supply(ref_sup), .sample_cap_select(cap_sel),
		.temp_sensor_enable(temp_en), .converting(conv),
		.standby_sleep(stby), .powerdown_sleep(pdown),
		.clock_request(clk_req), .result_ready_irq(rdy_irq),
		.window_compare_irq(win_irq));
	adc_core_model core_u (.hclk(hclk), .analog_level(level),
		.event_req(ev_req), .converting(conv), .input_select(in_sel),
		.result_ready_event(rr_ev),
		.event_start(ev_start), .core_sample_data(core_d),
		.core_over_range(over));
	//----------------------------------------------------------------
	// Reference model and checks
	//----------------------------------------------------------------
	// Window flag expected from mode, result and both thresholds
	function automatic logic win_exp(int m, int r, int l, int h);
		case (m)
			1: return r < l;
			2: return r > h;
			3: return r > l && r < h;
			4: return r < l || r > h;
			default: return 1'b0;
		endcase
	endfunction
	task chk32(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task chk1(input logic got, input logic exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task test_done;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	//----------------------------------------------------------------
	// Bus and conversion tasks
	//----------------------------------------------------------------
	// One single word transfer; waits on hready, never assumes a count
	task bus(input logic w, input logic [4:0] idx, input logic [31:0] wd);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {25'h0000000, idx, 2'h0};
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rdat = hrdata;
	endtask
	task rchk(input logic [4:0] idx, input logic [31:0] exp);
		bus(1'b0, idx, 32'h00000000);
		chk32(rdat, exp);
	endtask
	// Start by software write or by an event pulse
	task start(input logic by_event);
		if (by_event) begin
			@(posedge hclk) ev_req <= 1'b1;
			@(posedge hclk) ev_req <= 1'b0;
		end else
			bus(1'b1, adc_ctrl_pkg::IDX_COMMAND, 32'h00000001);
	endtask
	// Bounded wait for the result pulse, counting converting cycles
	task wait_res;
		cyc = 0;
		ncv = 0;
		while (rr_ev !== 1'b1 && cyc < 4000) begin
			@(posedge hclk);
			cyc++;
			if (conv === 1'b1) ncv++;
		end
		if (cyc >= 4000) begin
			err_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
		end
		@(posedge hclk);
		chk1(rr_ev, 1'b0);
	endtask
	//----------------------------------------------------------------
	// Clock, watchdog and main sequence
	//----------------------------------------------------------------
	initial begin
		hclk = 1'b0;
		forever #20 hclk = ~hclk;
	end
	// The whole run needs well under 10000 cycles
	initial begin
		repeat (30000) @(posedge hclk);
		err_count++;
		test_done;
	end
	initial begin
		{hresetn, hsel, hwrite, ev_req, stby, pdown} = 6'h00;
		{haddr, hwdata} = 64'h0;
		htrans = 2'h0;
		hsize = 3'h2;
		level = 11'h000;
		err_count = 0;
		n_compared = 0;
		void'($urandom(32'h55b7c6f4));
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		chk1(clk_req, 1'b0);
		rchk(adc_ctrl_pkg::IDX_CTRLA, 32'h0);
		rchk(adc_ctrl_pkg::IDX_INTFL, 32'h0);
		// Unmapped place: write is dropped, read gives zero
		bus(1'b1, 5'h07, 32'h000000FF);
		rchk(5'h07, 32'h0);
		bus(1'b1, adc_ctrl_pkg::IDX_CTRLA, 32'h00000001);
		// Both reference codes reach the active selection
		for (int r = 0; r < 2; r++) begin
			bus(1'b1, adc_ctrl_pkg::IDX_CTRLC, 32'(r) << 4);
			repeat (3) @(posedge hclk);
			chk1(ref_sup, r[0]);
			chk32({30'h0, ref_sel}, 32'(r));
		end
		bus(1'b1, adc_ctrl_pkg::IDX_INSEL, {27'h0, TEMP_CH});
		repeat (3) @(posedge hclk);
		chk1(temp_en, 1'b1);
		ch = $urandom_range(0, 29);
		bus(1'b1, adc_ctrl_pkg::IDX_INSEL, 32'(ch));
		repeat (3) @(posedge hclk);
		chk1(temp_en, 1'b0);
		chk32({27'h0, in_sel}, 32'(ch));
		// Channel moved during a conversion stays locked for it
		level = 11'($urandom_range(0, 1023));
		start(1'b0);
		repeat (4) @(posedge hclk);
		bus(1'b1, adc_ctrl_pkg::IDX_INSEL, 32'(ch ^ 1));
		chk32({27'h0, in_sel}, 32'(ch));
		wait_res;
		chk1(rdy_irq, 1'b0);
		rchk(adc_ctrl_pkg::IDX_INTFL, 32'h1);
		bus(1'b1, adc_ctrl_pkg::IDX_INTEN, 32'h1);
		@(posedge hclk);
		chk1(rdy_irq, 1'b1);
		rchk(adc_ctrl_pkg::IDX_RESULT, 32'((level ^ 11'(ch)) & 11'h3FF));
		@(posedge hclk);
		chk1(rdy_irq, 1'b0);
		ch = ch ^ 1;
		// Longer sample and an input above the reference
		bus(1'b1, adc_ctrl_pkg::IDX_SAMPCTRL, 32'h2);
		level = 11'h400 | 11'($urandom_range(0, 1023));
		start(1'b0);
		wait_res;
		chk1(ncv >= 29 && ncv <= 31, 1'b1);
		rchk(adc_ctrl_pkg::IDX_RESULT, 32'h3FF);
		bus(1'b1, adc_ctrl_pkg::IDX_SAMPCTRL, 32'h0);
		// Every window mode, thresholds around and at the result
		bus(1'b1, adc_ctrl_pkg::IDX_INTEN, 32'h3);
		for (int m = 0; m < 5; m++) begin
			for (int k = 0; k < 3; k++) begin
				d = $urandom_range(2, 1000);
				level = 11'(d ^ ch);
				lo = d - 1 + k;
				hi = d + 1 - k;
				bus(1'b1, adc_ctrl_pkg::IDX_CTRLE, 32'(m));
				bus(1'b1, adc_ctrl_pkg::IDX_WINLO, 32'(lo));
				bus(1'b1, adc_ctrl_pkg::IDX_WINHI, 32'(hi));
				start(1'b0);
				wait_res;
				chk1(win_irq, win_exp(m, d, lo, hi));
				rchk(adc_ctrl_pkg::IDX_INTFL, {30'h0, win_exp(m, d, lo, hi), 1'b1});
				bus(1'b1, adc_ctrl_pkg::IDX_INTFL, 32'h3);
				@(posedge hclk);
				chk1(win_irq, 1'b0);
			end
		end
		// Two samples: one result, compare on the sum only
		d = $urandom_range(100, 500);
		level = 11'(d ^ ch);
		bus(1'b1, adc_ctrl_pkg::IDX_CTRLB, 32'h1);
		bus(1'b1, adc_ctrl_pkg::IDX_CTRLE, 32'(adc_ctrl_pkg::WIN_ABOVE));
		bus(1'b1, adc_ctrl_pkg::IDX_WINHI, 32'(d + d / 2));
		start(1'b0);
		wait_res;
		n = 0;
		repeat (80) begin
			@(posedge hclk);
			if (rr_ev === 1'b1) n++;
		end
		chk32(32'(n), 32'h0);
		rchk(adc_ctrl_pkg::IDX_RESULT, 32'(2 * d));
		rchk(adc_ctrl_pkg::IDX_INTFL, 32'h2);
		bus(1'b1, adc_ctrl_pkg::IDX_INTFL, 32'h3);
		bus(1'b1, adc_ctrl_pkg::IDX_CTRLB, 32'h0);
		bus(1'b1, adc_ctrl_pkg::IDX_CTRLE, 32'h0);
		// Event start sets and then clears the start bit
		bus(1'b1, adc_ctrl_pkg::IDX_EVCTRL, 32'h1);
		start(1'b1);
		wait_res;
		rchk(adc_ctrl_pkg::IDX_COMMAND, 32'h0);
		rchk(adc_ctrl_pkg::IDX_INTFL, 32'h1);
		// Free-run: a channel change shows up one result late
		bus(1'b1, adc_ctrl_pkg::IDX_CTRLA, 32'h00000003);
		start(1'b0);
		repeat (4) @(posedge hclk);
		bus(1'b1, adc_ctrl_pkg::IDX_INSEL, 32'(ch ^ 2));
		wait_res;
		rchk(adc_ctrl_pkg::IDX_RESULT, 32'((level ^ 11'(ch)) & 11'h3FF));
		wait_res;
		rchk(adc_ctrl_pkg::IDX_RESULT, 32'((level ^ 11'(ch)) & 11'h3FF));
		wait_res;
		rchk(adc_ctrl_pkg::IDX_RESULT,
			32'((level ^ 11'(ch ^ 2)) & 11'h3FF));
		bus(1'b1, adc_ctrl_pkg::IDX_CTRLA, 32'h00000001);
		wait_res;
		ch = ch ^ 2;
		bus(1'b1, adc_ctrl_pkg::IDX_INTFL, 32'h3);
		// Power-down in mid-conversion: halts, then resumes and flags
		start(1'b0);
		@(posedge hclk);
		chk1(conv, 1'b0);
		@(posedge hclk);
		chk1(conv, 1'b1);
		pdown <= 1'b1;
		n = 0;
		repeat (60) begin
			@(posedge hclk);
			if (rr_ev === 1'b1) n++;
		end
		chk32(32'(n), 32'h0);
		pdown <= 1'b0;
		wait_res;
		rchk(adc_ctrl_pkg::IDX_INTFL, 32'h1);
		// Standby without run-in-standby: events do nothing
		stby <= 1'b1;
		start(1'b1);
		n = 0;
		repeat (150) begin
			@(posedge hclk);
			if (rr_ev === 1'b1) n++;
		end
		chk32(32'(n), 32'h0);
		chk1(clk_req, 1'b0);
		// Disable clears any pending start before standby is re-entered
		bus(1'b1, adc_ctrl_pkg::IDX_CTRLA, 32'h0);
		stby <= 1'b0;
		bus(1'b1, adc_ctrl_pkg::IDX_CTRLA, 32'h81);
		bus(1'b1, adc_ctrl_pkg::IDX_CTRLD, 32'h20);
		stby <= 1'b1;
		@(posedge hclk);
		start(1'b1);
		repeat (4) @(posedge hclk);
		chk1(clk_req, 1'b1);
		wait_res;
		chk1(cyc >= 50, 1'b1);
		repeat (4) @(posedge hclk);
		chk1(clk_req, 1'b0);
		test_done;
	end
endmodule

// file: dv/adc_core_model.sv
// Partner model: analog core and event router beside the control block.
// Assumes the bench sets the analog level and asks for events by level.
`timescale 1ns/1ps
module adc_core_model (
	// Clock
	input wire logic hclk,
	// Bench controls
	input wire logic [10:0] analog_level,
	input wire logic event_req,
	// Control block side
	input wire logic converting,
	input wire logic [4:0] input_select,
	input wire logic result_ready_event,
	output logic event_start,
	output logic [9:0] core_sample_data,
	output logic core_over_range
);
	logic [10:0] held_ff = 11'h000; // Level taken at sample-and-hold
	logic conv_q_ff = 1'b0; // Converting, one cycle late
	logic ev_ff = 1'b0; // Event line toward the block
	// Sample at the start of a conversion; a late channel change
	// must not leak into the result already being built
	always @(posedge hclk) begin
		conv_q_ff <= converting;
		// Free-run starts the next conversion right after each result
		if (converting && (!conv_q_ff || result_ready_event))
			held_ff <= analog_level ^ {6'h00, input_select};
		ev_ff <= event_req;
	end
	assign event_start = ev_ff;
	// Outside a conversion the lines carry inverted junk, not stale data
	assign core_sample_data = converting ? held_ff[9:0] : ~held_ff[9:0];
	assign core_over_range = converting ? held_ff[10] : ~held_ff[10];
endmodule

// file: rtl/adc_conversion_control.sv
// Conversion control: registers, start logic, sequencer, window compare.
// Assumes the analog core presents a settled sample at the last cycle of
// each conversion, and that sleep inputs are synchronous to hclk.
`timescale 1ns/1ps
module adc_conversion_control #(
	parameter logic [4:0] TEMP_CHANNEL = 5'h1E
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Event router
	input wire logic event_start,
	output logic result_ready_event,
	// Analog core
	input wire logic [9:0] core_sample_data,
	input wire logic core_over_range,
	output logic [4:0] input_select,
	output logic [1:0] reference_select,
	output logic ref_use_supply,
	output logic sample_cap_select,
	output logic temp_sensor_enable,
	output logic converting,
	// Power management
	input wire logic standby_sleep,
	input wire logic powerdown_sleep,
	output logic clock_request,
	// Interrupt requests
	output logic result_ready_irq,
	output logic window_compare_irq
);
	//------------------------------------------------------------------
	// State
	//------------------------------------------------------------------
	typedef struct packed {
		logic a_valid; // Pending data phase
		logic a_wr;
		logic [4:0] a_idx;
		logic [31:0] rdata;
		logic enable, free_run, res8, run_stby;
		logic [2:0] samp_num;
		logic samp_cap;
		logic [1:0] ref_shadow;
		logic [2:0] presc;
		logic [2:0] init_dly;
		logic [2:0] win_mode;
		logic [4:0] samp_len;
		logic [4:0] in_shadow;
		logic start, ev_en, ie_rdy, ie_win, f_rdy, f_win;
		logic [15:0] res, win_lo, win_hi;
		logic [4:0] in_act, in_cap; // Active and captured channel
		logic [1:0] ref_act, ref_cap;
		adc_ctrl_pkg::conv_state_type st;
		logic [8:0] pcnt; // Prescaler
		logic [7:0] acnt; // Converter clock cycles in phase
		logic [6:0] snum; // Samples taken
		logic [15:0] acc;
		logic ev_prev, rdy_pulse, stby_prev, init_pend;
	} state_type;

	state_type s_ff;
	state_type nxt_s;

	// Elaboration check on the channel code
	if (TEMP_CHANNEL == 5'h00) begin : g_chk
		$error("TEMP_CHANNEL must not alias channel zero");
	end

	//------------------------------------------------------------------
	// Derived values
	//------------------------------------------------------------------
	logic [8:0] div_m1; // Prescaler terminal count
	logic [7:0] conv_len;
	logic [7:0] dly_len;
	logic [2:0] samp_eff;
	logic [6:0] snum_last;
	logic tick; // One peripheral clock per converter clock
	logic last_cyc; // Last converter cycle of a conversion
	logic active_ok;
	logic [9:0] sat;
	logic [15:0] sval;
	logic [15:0] acc_n;
	logic win_hit;
	logic done_set;
	logic ahb_sel;

	always_comb begin
		div_m1 = 9'((9'h002 << s_ff.presc) - 9'h001);
		conv_len = adc_ctrl_pkg::CONV_BASE_CYCLES + {3'h0, s_ff.samp_len};
		dly_len = 8'({s_ff.init_dly, {adc_ctrl_pkg::INIT_DLY_SHIFT{1'b0}}});
		samp_eff = (s_ff.samp_num == adc_ctrl_pkg::SAMPNUM_RESERVED) ?
			3'h0 : s_ff.samp_num;
		snum_last = 7'((7'h01 << samp_eff) - 7'h01);
		tick = (s_ff.st != adc_ctrl_pkg::ST_IDLE) && !powerdown_sleep &&
			(s_ff.pcnt == div_m1);
		last_cyc = (s_ff.st == adc_ctrl_pkg::ST_CONV) &&
			(s_ff.acnt == conv_len - 8'h01);
		// Standby blocks new conversions unless told to keep running; one in flight still finishes
		active_ok = s_ff.enable && (!standby_sleep || s_ff.run_stby);
		// Over-range input reads as full scale
		sat = core_over_range ? adc_ctrl_pkg::FULL_SCALE : core_sample_data;
		sval = s_ff.res8 ? {8'h00, sat[9:2]} : {6'h00, sat};
		acc_n = 16'(s_ff.acc + sval);
		// Unsigned sixteen-bit window tests
		case (s_ff.win_mode)
			adc_ctrl_pkg::WIN_BELOW: win_hit = acc_n < s_ff.win_lo;
			adc_ctrl_pkg::WIN_ABOVE: win_hit = acc_n > s_ff.win_hi;
			adc_ctrl_pkg::WIN_INSIDE: win_hit = (acc_n > s_ff.win_lo) &&
				(acc_n < s_ff.win_hi);
			adc_ctrl_pkg::WIN_OUTSIDE: win_hit = (acc_n < s_ff.win_lo) ||
				(acc_n > s_ff.win_hi);
			default: win_hit = 1'b0;
		endcase
		done_set = tick && last_cyc && (s_ff.snum == snum_last);
		ahb_sel = hsel && htrans[1] && hready;
	end

	// Read view of the registers; reserved bits read as zero
	function automatic logic [31:0] read_mux(input state_type v,
		input logic [4:0] idx);
		logic [31:0] d;
		d = 32'h0000_0000;
		if (idx == adc_ctrl_pkg::IDX_CTRLA) begin
			d[adc_ctrl_pkg::B_ENABLE] = v.enable;
			d[adc_ctrl_pkg::B_FREERUN] = v.free_run;
			d[adc_ctrl_pkg::B_RES8] = v.res8;
			d[adc_ctrl_pkg::B_RUNSTBY] = v.run_stby;
		end else if (idx == adc_ctrl_pkg::IDX_CTRLB) begin
			d[2:0] = v.samp_num;
		end else if (idx == adc_ctrl_pkg::IDX_CTRLC) begin
			d[adc_ctrl_pkg::B_PRESC +: 3] = v.presc;
			d[adc_ctrl_pkg::B_REFERENCE_SELECT +: 2] = v.ref_shadow;
			d[adc_ctrl_pkg::B_SAMPLE_CAP_SELECT] = v.samp_cap;
		end else if (idx == adc_ctrl_pkg::IDX_CTRLD) begin
			d[adc_ctrl_pkg::B_INITIAL_DELAY +: 3] = v.init_dly;
		end else if (idx == adc_ctrl_pkg::IDX_CTRLE) begin
			d[2:0] = v.win_mode;
		end else if (idx == adc_ctrl_pkg::IDX_SAMPCTRL) begin
			d[4:0] = v.samp_len;
		end else if (idx == adc_ctrl_pkg::IDX_INSEL) begin
			d[4:0] = v.in_shadow;
		end else if (idx == adc_ctrl_pkg::IDX_COMMAND) begin
			d[0] = v.start;
		end else if (idx == adc_ctrl_pkg::IDX_EVCTRL) begin
			d[0] = v.ev_en;
		end else if (idx == adc_ctrl_pkg::IDX_INTEN) begin
			d[adc_ctrl_pkg::B_RDY] = v.ie_rdy;
			d[adc_ctrl_pkg::B_WIN] = v.ie_win;
		end else if (idx == adc_ctrl_pkg::IDX_INTFL) begin
			d[adc_ctrl_pkg::B_RDY] = v.f_rdy;
			d[adc_ctrl_pkg::B_WIN] = v.f_win;
		end else if (idx == adc_ctrl_pkg::IDX_RESULT) begin
			d[15:0] = v.res;
		end else if (idx == adc_ctrl_pkg::IDX_WINLO) begin
			d[15:0] = v.win_lo;
		end else if (idx == adc_ctrl_pkg::IDX_WINHI) begin
			d[15:0] = v.win_hi;
		end
		return d;
	endfunction

	//------------------------------------------------------------------
	// Next state
	//------------------------------------------------------------------
	always_comb begin
		nxt_s = s_ff;
		nxt_s.rdy_pulse = 1'b0;
		// Prescaler is held at zero while nothing runs, frozen in power-down
		if (s_ff.st == adc_ctrl_pkg::ST_IDLE) begin
			nxt_s.pcnt = 9'h000;
		end else if (!powerdown_sleep) begin
			nxt_s.pcnt = (s_ff.pcnt == div_m1) ? 9'h000 : s_ff.pcnt + 9'h001;
		end
		// Entering standby arms the initial delay
		nxt_s.stby_prev = standby_sleep;
		if (standby_sleep && !s_ff.stby_prev) begin
			nxt_s.init_pend = 1'b1;
		end
		// Event input is edge sensitive
		nxt_s.ev_prev = event_start;
		if (s_ff.ev_en && event_start && !s_ff.ev_prev && active_ok) begin
			nxt_s.start = 1'b1;
		end
		// Reading the result clears its flag; a same-cycle set still wins
		if (ahb_sel && !hwrite &&
			haddr[6:2] == adc_ctrl_pkg::IDX_RESULT) begin
			nxt_s.f_rdy = 1'b0;
		end
		// Register writes in the data phase
		if (s_ff.a_valid && s_ff.a_wr) begin
			if (s_ff.a_idx == adc_ctrl_pkg::IDX_CTRLA) begin
				nxt_s.enable = hwdata[adc_ctrl_pkg::B_ENABLE];
				nxt_s.free_run = hwdata[adc_ctrl_pkg::B_FREERUN];
				nxt_s.res8 = hwdata[adc_ctrl_pkg::B_RES8];
				nxt_s.run_stby = hwdata[adc_ctrl_pkg::B_RUNSTBY];
			end else if (s_ff.a_idx == adc_ctrl_pkg::IDX_CTRLB) begin
				nxt_s.samp_num = hwdata[2:0];
			end else if (s_ff.a_idx == adc_ctrl_pkg::IDX_CTRLC) begin
				nxt_s.presc = hwdata[adc_ctrl_pkg::B_PRESC +: 3];
				nxt_s.ref_shadow = hwdata[adc_ctrl_pkg::B_REFERENCE_SELECT +: 2];
				nxt_s.samp_cap = hwdata[adc_ctrl_pkg::B_SAMPLE_CAP_SELECT];
			end else if (s_ff.a_idx == adc_ctrl_pkg::IDX_CTRLD) begin
				nxt_s.init_dly = hwdata[adc_ctrl_pkg::B_INITIAL_DELAY +: 3];
			end else if (s_ff.a_idx == adc_ctrl_pkg::IDX_CTRLE) begin
				nxt_s.win_mode = hwdata[2:0];
			end else if (s_ff.a_idx == adc_ctrl_pkg::IDX_SAMPCTRL) begin
				nxt_s.samp_len = hwdata[4:0];
			end else if (s_ff.a_idx == adc_ctrl_pkg::IDX_INSEL) begin
				nxt_s.in_shadow = hwdata[4:0];
			end else if (s_ff.a_idx == adc_ctrl_pkg::IDX_COMMAND) begin
				// Writing zero does not abort a conversion
				if (hwdata[0] && s_ff.enable) begin
					nxt_s.start = 1'b1;
				end
			end else if (s_ff.a_idx == adc_ctrl_pkg::IDX_EVCTRL) begin
				nxt_s.ev_en = hwdata[0];
			end else if (s_ff.a_idx == adc_ctrl_pkg::IDX_INTEN) begin
				nxt_s.ie_rdy = hwdata[adc_ctrl_pkg::B_RDY];
				nxt_s.ie_win = hwdata[adc_ctrl_pkg::B_WIN];
			end else if (s_ff.a_idx == adc_ctrl_pkg::IDX_INTFL) begin
				// Write one to clear
				if (hwdata[adc_ctrl_pkg::B_RDY]) begin
					nxt_s.f_rdy = 1'b0;
				end
				if (hwdata[adc_ctrl_pkg::B_WIN]) begin
					nxt_s.f_win = 1'b0;
				end
			end else if (s_ff.a_idx == adc_ctrl_pkg::IDX_WINLO) begin
				nxt_s.win_lo = hwdata[15:0];
			end else if (s_ff.a_idx == adc_ctrl_pkg::IDX_WINHI) begin
				nxt_s.win_hi = hwdata[15:0];
			end
		end
		// Selections follow the shadow except while locked
		if (s_ff.st != adc_ctrl_pkg::ST_CONV) begin
			nxt_s.in_act = s_ff.in_shadow;
			nxt_s.ref_act = s_ff.ref_shadow;
		end else if (last_cyc) begin
			// Free-run takes what was captured one conversion back
			nxt_s.in_act = s_ff.free_run ? s_ff.in_cap : s_ff.in_shadow;
			nxt_s.ref_act = s_ff.free_run ? s_ff.ref_cap : s_ff.ref_shadow;
		end
		// Conversion sequencer
		case (s_ff.st)
			adc_ctrl_pkg::ST_IDLE: begin
				if (s_ff.start && active_ok && !powerdown_sleep) begin
					nxt_s.in_cap = s_ff.in_shadow;
					nxt_s.ref_cap = s_ff.ref_shadow;
					nxt_s.acnt = 8'h00;
					nxt_s.snum = 7'h00;
					nxt_s.acc = 16'h0000;
					nxt_s.init_pend = 1'b0;
					if (standby_sleep && s_ff.init_pend &&
						s_ff.init_dly != 3'h0) begin
						nxt_s.st = adc_ctrl_pkg::ST_DELAY;
					end else begin
						nxt_s.st = adc_ctrl_pkg::ST_CONV;
					end
				end
			end
			adc_ctrl_pkg::ST_DELAY: begin
				if (tick) begin
					nxt_s.acnt = s_ff.acnt + 8'h01;
					if (s_ff.acnt == dly_len - 8'h01) begin
						nxt_s.acnt = 8'h00;
						nxt_s.st = adc_ctrl_pkg::ST_CONV;
					end
				end
			end
			adc_ctrl_pkg::ST_CONV: begin
				if (tick) begin
					nxt_s.acnt = s_ff.acnt + 8'h01;
					if (last_cyc) begin
						nxt_s.acnt = 8'h00;
						nxt_s.snum = s_ff.snum + 7'h01;
						nxt_s.acc = acc_n;
						if (done_set) begin
							// Result is only compared once it is final
							nxt_s.res = acc_n;
							nxt_s.f_rdy = 1'b1;
							nxt_s.rdy_pulse = 1'b1;
							if (s_ff.win_mode != adc_ctrl_pkg::WIN_OFF &&
								win_hit) begin
								nxt_s.f_win = 1'b1;
							end
							nxt_s.snum = 7'h00;
							nxt_s.acc = 16'h0000;
							if (s_ff.free_run && s_ff.start && active_ok) begin
								nxt_s.in_cap = s_ff.in_shadow;
								nxt_s.ref_cap = s_ff.ref_shadow;
							end else begin
								nxt_s.st = adc_ctrl_pkg::ST_IDLE;
								nxt_s.start = 1'b0;
							end
						end
					end
				end
			end
			default: nxt_s.st = adc_ctrl_pkg::ST_IDLE;
		endcase
		// Disabling drops any conversion in flight
		if (!nxt_s.enable) begin
			nxt_s.st = adc_ctrl_pkg::ST_IDLE;
			nxt_s.start = 1'b0;
		end
		// Address phase capture; read data sees this cycle's updates
		nxt_s.a_valid = ahb_sel;
		nxt_s.a_wr = hwrite;
		nxt_s.a_idx = haddr[6:2];
		if (ahb_sel && !hwrite) begin
			nxt_s.rdata = read_mux(nxt_s, haddr[6:2]);
		end
	end

	//------------------------------------------------------------------
	// State register
	//------------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	//------------------------------------------------------------------
	// Outputs
	//------------------------------------------------------------------
	assign hreadyout = 1'b1; // Zero wait states
	assign hresp = 1'b0;
	assign hrdata = s_ff.rdata;
	assign result_ready_event = s_ff.rdy_pulse;
	assign input_select = s_ff.in_act;
	assign reference_select = s_ff.ref_act;
	assign ref_use_supply = (s_ff.ref_act == adc_ctrl_pkg::REF_SUPPLY);
	assign sample_cap_select = s_ff.samp_cap;
	assign temp_sensor_enable = (s_ff.in_act == TEMP_CHANNEL);
	assign converting = (s_ff.st == adc_ctrl_pkg::ST_CONV);
	// Peripheral clock is only needed while an initial delay or a conversion is under way
	assign clock_request = (s_ff.st != adc_ctrl_pkg::ST_IDLE);
	assign result_ready_irq = s_ff.ie_rdy && s_ff.f_rdy;
	assign window_compare_irq = s_ff.ie_win && s_ff.f_win;

	//------------------------------------------------------------------
	// Assertions
	//------------------------------------------------------------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	property p_flag_with_event;
		s_ff.rdy_pulse |-> s_ff.f_rdy && !s_ff.start ||
			s_ff.rdy_pulse && s_ff.f_rdy && s_ff.free_run;
	endproperty
	a_flag_with_event: assert property (p_flag_with_event)
		else $error("result event without flag");

	property p_irq_hold;
		$fell(result_ready_irq) |-> !s_ff.f_rdy || !s_ff.ie_rdy;
	endproperty
	a_irq_hold: assert property (p_irq_hold)
		else $error("request dropped while flag and enable set");

	property p_pulse_single;
		s_ff.rdy_pulse |=> !s_ff.rdy_pulse [*8];
	endproperty
	a_pulse_single: assert property (p_pulse_single)
		else $error("result event longer than one clock");

	property p_locked;
		s_ff.st == adc_ctrl_pkg::ST_CONV &&
		$past(s_ff.st) == adc_ctrl_pkg::ST_CONV && !$past(last_cyc)
		|-> $stable(s_ff.in_act) && $stable(s_ff.ref_act);
	endproperty
	a_locked: assert property (p_locked)
		else $error("selection moved during conversion");

	property p_follow;
		s_ff.st == adc_ctrl_pkg::ST_IDLE &&
		$past(s_ff.st) == adc_ctrl_pkg::ST_IDLE
		|-> s_ff.in_act == $past(s_ff.in_shadow);
	endproperty
	a_follow: assert property (p_follow)
		else $error("active channel not following shadow");

	property p_start;
		s_ff.start && s_ff.st == adc_ctrl_pkg::ST_IDLE && active_ok &&
		!powerdown_sleep && !(s_ff.a_valid && s_ff.a_wr)
		|=> s_ff.st != adc_ctrl_pkg::ST_IDLE ##1 s_ff.pcnt == 9'h001;
	endproperty
	a_start: assert property (p_start)
		else $error("conversion did not begin after start");

	property p_win_once;
		$rose(s_ff.f_win) |-> s_ff.rdy_pulse;
	endproperty
	a_win_once: assert property (p_win_once)
		else $error("window flag outside a final result");

	property p_read_clear;
		ahb_sel && !hwrite && haddr[6:2] == adc_ctrl_pkg::IDX_RESULT &&
		!done_set |=> !s_ff.f_rdy;
	endproperty
	a_read_clear: assert property (p_read_clear)
		else $error("result read did not clear flag");

	c_result: cover property (s_ff.rdy_pulse);
	c_window: cover property ($rose(s_ff.f_win));
	c_freerun: cover property (s_ff.rdy_pulse &&
		s_ff.st == adc_ctrl_pkg::ST_CONV);
	c_delay: cover property (s_ff.st == adc_ctrl_pkg::ST_DELAY);
endmodule

// file: rtl/adc_ctrl_pkg.sv
// Constants, field layout and state types for the converter control block.
// Assumes a single 25 MHz peripheral clock and an AHB-Lite register port.
//----------------------------------------------------------------------
// Overview of operation
// - Shadow selections copy to active while idle
// - Selections frozen; copying resumes in last cycle
// - Start begins on next converter clock edge
// - Free-run: next result keeps the old channel
// - Over-range input saturates at code 1023
// - Reference select 0 means internal reference
// - Temperature channel enables the temperature sensor
// - Window mode 1 to 4 picks one of four
// - Inside and outside window use strict compares
// - Window compare only on final accumulated result
// - Flags set even when interrupt disabled
// - Request held while enable and flag set
// - One-clock result ready event per result
// - Rising event edge sets start and converts
// - Standby blocks new conversions unless run-in-standby set; one in flight still finishes
// - Standby clock requested only while delaying or converting
// - First standby conversion waits the initial delay
// - Power-down halts conversion; resumes, still flags
// - Reading result or writing one clears flag
// - Plain conversion lasts thirteen converter cycles
package adc_ctrl_pkg;
	// Register indexes; byte address is index times four
	localparam logic [4:0] IDX_CTRLA = 5'h00;
	localparam logic [4:0] IDX_CTRLB = 5'h01;
	localparam logic [4:0] IDX_CTRLC = 5'h02;
	localparam logic [4:0] IDX_CTRLD = 5'h03;
	localparam logic [4:0] IDX_CTRLE = 5'h04;
	localparam logic [4:0] IDX_SAMPCTRL = 5'h05;
	localparam logic [4:0] IDX_INSEL = 5'h06;
	localparam logic [4:0] IDX_COMMAND = 5'h08;
	localparam logic [4:0] IDX_EVCTRL = 5'h09;
	localparam logic [4:0] IDX_INTEN = 5'h0A;
	localparam logic [4:0] IDX_INTFL = 5'h0B;
	localparam logic [4:0] IDX_RESULT = 5'h10;
	localparam logic [4:0] IDX_WINLO = 5'h12;
	localparam logic [4:0] IDX_WINHI = 5'h14;
	// Field positions
	localparam int B_ENABLE = 0;
	localparam int B_FREERUN = 1;
	localparam int B_RES8 = 2;
	localparam int B_RUNSTBY = 7;
	localparam int B_PRESC = 0;
	localparam int B_REFERENCE_SELECT = 4;
	localparam int B_SAMPLE_CAP_SELECT = 6;
	localparam int B_INITIAL_DELAY = 5;
	localparam int B_RDY = 0;
	localparam int B_WIN = 1;
	// Timing and codes
	localparam logic [7:0] CONV_BASE_CYCLES = 8'h0D;
	localparam logic [9:0] FULL_SCALE = 10'h3FF;
	localparam int INIT_DLY_SHIFT = 4;
	localparam logic [2:0] SAMPNUM_RESERVED = 3'h7;
	localparam logic [1:0] REF_INTERNAL = 2'h0;
	localparam logic [1:0] REF_SUPPLY = 2'h1;
	// Window modes
	localparam logic [2:0] WIN_OFF = 3'h0;
	localparam logic [2:0] WIN_BELOW = 3'h1;
	localparam logic [2:0] WIN_ABOVE = 3'h2;
	localparam logic [2:0] WIN_INSIDE = 3'h3;
	localparam logic [2:0] WIN_OUTSIDE = 3'h4;
	// Sequencer states
	typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_CONV} conv_state_type;
endpackage
